// ---- boot_switch_config_register_test.sv ----
// Purpose: Self-checking bench for the switch configuration block
// Assumes: Zero wait state APB, one clock, async active-low reset
// Notes:   APB reads are scored through a queue of expected words
`include "bsc_defines.svh"
module boot_switch_config_register_test
   import bsc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic        sys_clk = 1'b0;
   logic        reset_n = 1'b0;
   logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata;
   logic        pready, pslverr;
   logic [3:0]  hi_sw, lo_sw;
   logic        diag_done = 1'b0, boot_failed = 1'b0, tx_in = 1'b1, rx_stb = 1'b0;
   logic        console_txd, dis_err, boot_err;
   logic [2:0]  mode, entry;
   logic [16:0] baud;
   logic [1:8]  sw_on = 8'h00;
   logic [32:0] exp_q[$];
   logic [32:0] e;
   logic [7:0]  v;
   logic        prev;
   int          error_cnt = 0, checked = 0, cyc = 0;
   // Decode cases: switch word, select enable, mode, entry
   logic [7:0]  cv[0:8] = '{8'h88, 8'he8, 8'h80, 8'h00, 8'hf0, 8'h70, 8'h90, 8'h60, 8'hb0};
   logic        ce[0:8] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
   bsc_mode_t   cm[0:8] = '{BSC_MODE_DIALOG, BSC_MODE_DIALOG, BSC_MODE_MONITOR, BSC_MODE_SELFTST,
                            BSC_MODE_STORED, BSC_MODE_AUTO, BSC_MODE_SINGLE, BSC_MODE_SINGLE,
                            BSC_MODE_STORED};
   logic [2:0]  cn[0:8] = '{3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h1, 3'h6, 3'h0};

   always #20 sys_clk = ~sys_clk;
   // ----------------------------------------------------------------------
   // Design and far side
   // ----------------------------------------------------------------------
   bsc_switch_config u_dut (.sys_clk(sys_clk), .reset_n(reset_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .remote_cable_high_switches(hi_sw),
      .remote_cable_low_switches(lo_sw), .diag_done(diag_done), .boot_failed(boot_failed),
      .tx_in(tx_in), .rx_char_strobe(rx_stb), .console_txd(console_txd),
      .console_disabled_err(dis_err), .powerup_mode(mode), .baud_rate(baud),
      .boot_entry(entry), .boot_err_report(boot_err));
   bsc_switch_panel u_panel (.sys_clk(sys_clk), .sw_on(sw_on),
      .remote_cable_high_switches(hi_sw), .remote_cable_low_switches(lo_sw));
   // ----------------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------------
   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : stop_test
   task automatic chk(input logic [32:0] got, input logic [32:0] want, input string msg);
      checked++;
      if (got !== want) begin
         error_cnt++;
         $display("CHECK FAILED t=%0t %s got %h want %h", $time, msg, got, want);
      end
   endtask : chk
   // Switch word bit 8-k belongs to switch k; on means reads 0
   task automatic set_sw(input logic [7:0] r);
      for (int k = 1; k <= 8; k++) begin
         sw_on[k] <= ~r[8-k];
      end
   endtask : set_sw
   // One APB transfer; a read notes its expected {pslverr, prdata}
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                      input logic [32:0] x);
      @(posedge sys_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      if (!w) exp_q.push_back(x);
      @(posedge sys_clk);
      penable <= 1'b1;
      @(posedge sys_clk);
      while (pready !== 1'b1) begin
         @(posedge sys_clk);
      end
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic rst(input logic [7:0] r);
      reset_n <= 1'b0;
      set_sw(r);
      repeat (3) @(posedge sys_clk);
      reset_n <= 1'b1;
      repeat (2) @(posedge sys_clk);
   endtask : rst
   // Read data scored at the edge that completes the access
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc > 20000) begin
         error_cnt++;
         stop_test();
      end
      if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && pwrite === 1'b0) begin
         if (exp_q.size() == 0) begin
            chk(33'h0, 33'h1, "unexpected read");
         end else begin
            e = exp_q.pop_front();
            chk({pslverr, prdata}, e, "read data");
         end
      end
   end
   // ----------------------------------------------------------------------
   // Tests
   // ----------------------------------------------------------------------
   initial begin
      void'($urandom(32'h1e56b7cf));
      repeat (20) @(posedge sys_clk);
      reset_n <= 1'b1;
      // Register map, read only, unmapped
      for (int i = 0; i < 12; i++) begin
         v = 8'($urandom());
         set_sw(v);
         repeat (2) @(posedge sys_clk);
         apb(1'b0, `BSC_OFF_SWCFG, 32'h0, {25'h0, v});
         apb(1'b1, `BSC_OFF_SWCFG, ~{24'h0, v}, 33'h0);
         apb(1'b0, `BSC_OFF_SWCFG, 32'h0, {25'h0, v});
         apb(1'b0, `BSC_OFF_CONSOLE, 32'h0, {16'h0, 17'd38400 >> v[2:0]});
      end
      apb(1'b0, 12'h040, 32'h0, {1'b1, 32'h0});
      $display("test registers done");
      // Power-up decode per switch case, then failed boot
      for (int i = 0; i < 9; i++) begin
         v = cv[i] | 8'($urandom() & 7);
         rst(v);
         apb(1'b0, `BSC_OFF_SETUP, 32'h0, 33'h0);
         apb(1'b1, `BSC_OFF_SETUP, {31'h0, ce[i]}, 33'h0);
         apb(1'b0, `BSC_OFF_SETUP, 32'h0, {32'h0, ce[i]});
         apb(1'b1, 12'h014, {24'h0, v}, 33'h0);
         @(posedge sys_clk) diag_done <= 1'b1;
         @(posedge sys_clk) diag_done <= 1'b0;
         repeat (3) @(posedge sys_clk);
         @(negedge sys_clk);
         chk({30'h0, mode}, {30'h0, cm[i]}, "mode");
         chk({30'h0, entry}, {30'h0, cn[i]}, "entry");
         chk({16'h0, baud}, {16'h0, 17'd38400 >> v[2:0]}, "baud");
         apb(1'b0, `BSC_OFF_BOOTTAB, 32'h0, {25'h0, (cn[i] == 3'h1) ? v : 8'h0});
         if (cm[i] == BSC_MODE_SINGLE) begin
            @(posedge sys_clk) boot_failed <= 1'b1;
            @(posedge sys_clk) boot_failed <= 1'b0;
            @(negedge sys_clk);
            chk({32'h0, boot_err}, 33'h1, "boot error report");
            @(negedge sys_clk);
            chk({30'h0, mode}, {30'h0, BSC_MODE_DIALOG}, "dialog after fail");
         end
      end
      $display("test decode done");
      // Console gate, on then off
      for (int c = 1; c >= 0; c--) begin
         rst({c[0], 7'h70});
         prev = tx_in;
         for (int i = 0; i < 16; i++) begin
            @(posedge sys_clk) tx_in <= 1'($urandom());
            @(negedge sys_clk);
            chk({32'h0, console_txd}, {32'h0, c[0] ? prev : 1'b1}, "txd");
            prev = tx_in;
         end
         @(posedge sys_clk) rx_stb <= 1'b1;
         @(posedge sys_clk) rx_stb <= 1'b0;
         @(negedge sys_clk);
         chk({32'h0, dis_err}, {32'h0, ~c[0]}, "disabled error");
         @(negedge sys_clk);
         chk({32'h0, dis_err}, 33'h0, "error pulse end");
      end
      $display("test console done");
      repeat (4) @(posedge sys_clk);
      stop_test();
   end
endmodule : boot_switch_config_register_test

// ---- bsc_boot_table.sv ----
// Purpose: Six-entry store of boot program codes
// Assumes: Written by software over the bus, read by index
// Notes:   Read data registered; entries clear at reset
`include "bsc_defines.svh"

module bsc_boot_table
   import bsc_pkg::*;
(
   input  wire logic                       sys_clk,
   input  wire logic                       reset_n,
   input  wire logic                       wr_en,
   input  wire logic [`BSC_BOOT_IDX_W-1:0] wr_idx,
   input  wire logic [`BSC_BOOT_W-1:0]     wr_data,
   input  wire logic [`BSC_BOOT_IDX_W-1:0] rd_idx,
   output logic      [`BSC_BOOT_W-1:0]     rd_data_q
);

   logic [`BSC_BOOT_W-1:0] mem_q [`BSC_BOOT_ENTRIES];

   // ----------------------------------------------------------------------
   // Storage; index out of range writes nothing
   // ----------------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         for (int i = 0; i < `BSC_BOOT_ENTRIES; i++) begin
            mem_q[i] <= '0;
         end
      end else if (wr_en && (wr_idx < `BSC_BOOT_IDX_W'(`BSC_BOOT_ENTRIES))) begin
         mem_q[wr_idx] <= wr_data; // RULE17
      end
   end

   // Registered read, zero beyond the six entries
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         rd_data_q <= '0;
      end else if (rd_idx < `BSC_BOOT_IDX_W'(`BSC_BOOT_ENTRIES)) begin
         rd_data_q <= mem_q[rd_idx];
      end else begin
         rd_data_q <= '0;
      end
   end

endmodule : bsc_boot_table

// ---- bsc_defines.svh ----
// Purpose: Offsets, field positions, reset values and constants for the switch block
// Assumes: 32-bit APB, byte addresses, one aligned word per register
// Notes:   Definitions only
`ifndef BSC_DEFINES_SVH
`define BSC_DEFINES_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define BSC_OFF_SWCFG       12'h000
`define BSC_OFF_SETUP       12'h004
`define BSC_OFF_DECODE      12'h008
`define BSC_OFF_CONSOLE     12'h00c
`define BSC_OFF_BOOTTAB     12'h010
`define BSC_ADDR_W          12

// ----------------------------------------------------------------------
// Switch register fields
// ----------------------------------------------------------------------
`define BSC_BIT_CONSOLE     7
`define BSC_SEL_HI          6
`define BSC_SEL_LO          4
`define BSC_BIT_DIALOG      3
`define BSC_BAUD_HI         2
`define BSC_BAUD_LO         0

// ----------------------------------------------------------------------
// Setup register fields
// ----------------------------------------------------------------------
`define BSC_SETUP_SELEN     0
`define BSC_SETUP_PMODE_LO  1
`define BSC_SETUP_PMODE_HI  2
`define BSC_SETUP_RESET     3'h0

// ----------------------------------------------------------------------
// Misc constants
// ----------------------------------------------------------------------
`define BSC_SEL_NONE        3'h0
`define BSC_SEL_ALL         3'h7
`define BSC_BOOT_ENTRIES    6
`define BSC_BOOT_IDX_W      3
`define BSC_BOOT_W          8
`define BSC_BAUD_MAX        17'd38400
`define BSC_BAUD_W          17
`define BSC_SLVERR_ZERO     32'h0000_0000

`endif

// ---- bsc_pkg.sv ----
// Purpose: Types shared by the switch configuration block
// Assumes: Constants live in bsc_defines.svh
// Notes:   Gray-coded power-up sequencer states
package bsc_pkg;

   // ----------------------------------------------------------------------
   // Power-up outcome
   // ----------------------------------------------------------------------
   typedef enum logic [2:0] {
      BSC_MODE_NONE    = 3'h0,
      BSC_MODE_DIALOG  = 3'h1,
      BSC_MODE_AUTO    = 3'h2,
      BSC_MODE_SINGLE  = 3'h3,
      BSC_MODE_MONITOR = 3'h4,
      BSC_MODE_SELFTST = 3'h5,
      BSC_MODE_STORED  = 3'h6
   } bsc_mode_t;

   // Stored power-up parameter choices
   typedef enum logic [1:0] {
      BSC_PM_DIALOG  = 2'h0,
      BSC_PM_AUTO    = 2'h1,
      BSC_PM_MONITOR = 2'h2,
      BSC_PM_MODE24  = 2'h3
   } bsc_pmode_t;

   // Sequencer states, Gray along the usual path
   typedef enum logic [1:0] {
      BSC_ST_DIAG   = 2'b00,
      BSC_ST_DECIDE = 2'b01,
      BSC_ST_RUN    = 2'b11,
      BSC_ST_FAIL   = 2'b10
   } bsc_state_t;

   // Decoded switch word
   typedef struct packed {
      logic       console_en;
      logic [2:0] boot_sel;
      logic       force_dialog;
      logic [2:0] baud_code;
   } bsc_swcfg_t;

   // APB request carrier
   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } bsc_apb_req_t;

endpackage : bsc_pkg

// ---- bsc_switch_config.sv ----
// Purpose: Switch configuration register, power-up decode and console gate
// Assumes: Switch lines synchronous to sys_clk, low when closed to ground
// Notes:   APB slave, zero wait states, unmapped reads return zero with pslverr
//
// Behaviour
// RULE1 - Switch 1 lands on bit 7, down to switch 8 on bit 0.
// RULE2 - Closed switch reads 0, open switch reads 1.
// RULE3 - Remote control: local switches off, ground a cable line for on.
// RULE4 - Bits 2..0 pick console baud, 38400 halving down to 300.
// RULE5 - Switch 5 off sets bit 3, forcing dialog after diagnostics.
// RULE6 - With bit 3 set, skip auto boot and ignore boot select.
// RULE7 - Boot select counts only when enabled in stored setup.
// RULE8 - Select 1..6 boots only that stored entry in auto mode; code reads index = select, so select 6 reads zero.
// RULE9 - Failed selected boot reports error then enters dialog.
// RULE10 - Select zero with console enabled enters debug monitor mode.
// RULE11 - Select zero with console disabled loops self-tests.
// RULE12 - Select all ones, console on: stored power-up mode applies.
// RULE13 - Select all ones, console off: auto boot in stored order.
// RULE14 - Switch 1 off sets bit 7, enabling the console.
// RULE15 - Disabled console suppresses all transmit output.
// RULE16 - Received character while disabled raises a console-disabled error.
// RULE17 - Store holds six numbered boot program entries; bus writes reach only entries 0..3, at offsets 0x010..0x01C.
// RULE18 - Register read has no side effects; writes ignored.
//
// Implementation choices: the APB slave port and the register offsets.
`include "bsc_defines.svh"

module bsc_switch_config
   import bsc_pkg::*;
(
   input  wire logic        sys_clk,
   input  wire logic        reset_n,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic [3:0]  remote_cable_high_switches, // Switches 1..4, index 3 = sw1
   input  wire logic [3:0]  remote_cable_low_switches,  // Switches 5..8, index 3 = sw5
   input  wire logic        diag_done,
   input  wire logic        boot_failed,
   input  wire logic        tx_in,
   input  wire logic        rx_char_strobe,
   output logic             console_txd,
   output logic             console_disabled_err,
   output logic [2:0]       powerup_mode,
   output logic [16:0]      baud_rate,
   output logic [2:0]       boot_entry,
   output logic             boot_err_report
);

   bsc_swcfg_t   sw_q;
   bsc_state_t   state_q;
   bsc_mode_t    mode_q;
   bsc_mode_t    mode_d;
   logic [2:0]   setup_q;
   logic [31:0]  prdata_q;
   logic         pslverr_q;
   logic         txd_q;
   logic         rxerr_q;
   logic         booterr_q;
   logic [16:0]  baud_q;
   logic [2:0]   entry_q;
   logic [7:0]   tab_rd;
   logic         acc;
   logic         wr;

   assign acc = psel && penable;
   assign wr  = acc && pwrite;

   // ----------------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------------
   // Halve per code step; shift keeps it exact for all eight codes
   function automatic logic [16:0] baud_of(input logic [2:0] code);
      baud_of = `BSC_BAUD_MAX >> code; // RULE4
   endfunction : baud_of

   function automatic logic sel_is_entry(input logic [2:0] sel);
      sel_is_entry = (sel != `BSC_SEL_NONE) && (sel != `BSC_SEL_ALL);
   endfunction : sel_is_entry

   // ----------------------------------------------------------------------
   // Switch register: live levels, no reset needed but given one
   // ----------------------------------------------------------------------
   // Open switch floats high so line level is the bit directly
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         sw_q <= '1;
      end else begin
         sw_q <= {remote_cable_high_switches, remote_cable_low_switches}; // RULE1 RULE2 RULE3
      end
   end

   // ----------------------------------------------------------------------
   // Setup register: select enable and stored power-up mode
   // ----------------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         setup_q <= `BSC_SETUP_RESET;
      end else if (wr && paddr == `BSC_OFF_SETUP) begin
         setup_q <= pwdata[`BSC_SETUP_PMODE_HI:`BSC_SETUP_SELEN]; // RULE7
      end
   end

   // ----------------------------------------------------------------------
   // Power-up decision
   // ----------------------------------------------------------------------
   always_comb begin
      mode_d = BSC_MODE_NONE;
      if (sw_q.force_dialog) begin
         mode_d = BSC_MODE_DIALOG; // RULE5 RULE6
      end else if (sw_q.boot_sel == `BSC_SEL_NONE) begin
         mode_d = sw_q.console_en ? BSC_MODE_MONITOR : BSC_MODE_SELFTST; // RULE10 RULE11
      end else if (sw_q.boot_sel == `BSC_SEL_ALL) begin
         mode_d = sw_q.console_en ? BSC_MODE_STORED : BSC_MODE_AUTO; // RULE12 RULE13
      end else if (setup_q[`BSC_SETUP_SELEN]) begin
         mode_d = BSC_MODE_SINGLE; // RULE8
      end else begin
         mode_d = sw_q.console_en ? BSC_MODE_STORED : BSC_MODE_AUTO; // RULE7
      end
   end

   // Sequencer: wait for diagnostics, decide, run, fall back on failure
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         state_q   <= BSC_ST_DIAG;
         mode_q    <= BSC_MODE_NONE;
         entry_q   <= '0;
         booterr_q <= 1'b0;
      end else begin
         booterr_q <= 1'b0;
         case (state_q)
            BSC_ST_DIAG: begin
               if (diag_done) begin
                  state_q <= BSC_ST_DECIDE;
               end
            end
            BSC_ST_DECIDE: begin
               mode_q  <= mode_d;
               entry_q <= (mode_d == BSC_MODE_SINGLE) ? sw_q.boot_sel : '0;
               state_q <= BSC_ST_RUN;
            end
            BSC_ST_RUN: begin
               if (boot_failed && mode_q == BSC_MODE_SINGLE) begin
                  booterr_q <= 1'b1; // RULE9
                  state_q   <= BSC_ST_FAIL;
               end
            end
            BSC_ST_FAIL: begin
               mode_q  <= BSC_MODE_DIALOG; // RULE9
               state_q <= BSC_ST_RUN;
            end
            default: begin
               state_q <= BSC_ST_DIAG;
            end
         endcase
      end
   end

   // Baud value trails the switch register by one cycle
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         baud_q <= `BSC_BAUD_MAX;
      end else begin
         baud_q <= baud_of(sw_q.baud_code); // RULE4
      end
   end

   // ----------------------------------------------------------------------
   // Console gate
   // ----------------------------------------------------------------------
   // Line idles high (mark) when muted so the terminal sees no start bit
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         txd_q <= 1'b1;
      end else begin
         txd_q <= sw_q.console_en ? tx_in : 1'b1; // RULE14 RULE15
      end
   end

   // One-cycle error pulse per received character while disabled
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         rxerr_q <= 1'b0;
      end else begin
         rxerr_q <= rx_char_strobe && !sw_q.console_en; // RULE16
      end
   end

   // ----------------------------------------------------------------------
   // Boot table
   // ----------------------------------------------------------------------
   bsc_boot_table u_tab (
      .sys_clk   (sys_clk),
      .reset_n   (reset_n),
      .wr_en     (wr && (paddr[11:5] == 7'(`BSC_OFF_BOOTTAB >> 5)) && paddr[4]),
      .wr_idx    (paddr[4:2] - 3'h4),
      .wr_data   (pwdata[7:0]),
      .rd_idx    (entry_q),
      .rd_data_q (tab_rd)
   );

   // ----------------------------------------------------------------------
   // APB read mux; reads never alter state
   // ----------------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         prdata_q  <= '0;
         pslverr_q <= 1'b0;
      end else begin
         prdata_q  <= '0;
         pslverr_q <= 1'b0;
         if (psel && !penable && !pwrite) begin
            case (paddr)
               `BSC_OFF_SWCFG:   prdata_q <= {24'h0, sw_q}; // RULE18
               `BSC_OFF_SETUP:   prdata_q <= {29'h0, setup_q};
               `BSC_OFF_DECODE:  prdata_q <= {16'h0, entry_q, state_q, mode_q, 5'h0, mode_d};
               `BSC_OFF_CONSOLE: prdata_q <= {15'h0, baud_q};
               `BSC_OFF_BOOTTAB: prdata_q <= {24'h0, tab_rd};
               default: begin
                  prdata_q  <= `BSC_SLVERR_ZERO;
                  pslverr_q <= 1'b1;
               end
            endcase
         end
      end
   end

   assign prdata  = prdata_q;
   assign pready  = 1'b1;
   assign pslverr = pslverr_q; // Loaded in setup, cleared after the access cycle

   // ----------------------------------------------------------------------
   // Registered outputs
   // ----------------------------------------------------------------------
   assign console_txd          = txd_q;
   assign console_disabled_err = rxerr_q;
   assign powerup_mode         = mode_q;
   assign baud_rate            = baud_q;
   assign boot_entry           = entry_q;
   assign boot_err_report      = booterr_q;

   // ----------------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------------
   AST_BIT_ORDER: assert property (@(posedge sys_clk) disable iff (!reset_n)
      $past(reset_n) |-> sw_q.console_en == $past(remote_cable_high_switches[3])) // RULE1
      else $error("switch 1 not on bit 7");
   AST_LEVEL: assert property (@(posedge sys_clk) disable iff (!reset_n)
      !remote_cable_low_switches[3] |=> !sw_q.force_dialog) // RULE2
      else $error("closed switch not read as zero");
   AST_BAUD: assert property (@(posedge sys_clk) disable iff (!reset_n)
      sw_q.baud_code == 3'h7 |=> baud_q == 17'd300) // RULE4
      else $error("baud code seven not 300");
   AST_DIALOG: assert property (@(posedge sys_clk) disable iff (!reset_n)
      state_q == BSC_ST_DECIDE && sw_q.force_dialog |=> mode_q == BSC_MODE_DIALOG) // RULE5
      else $error("force dialog ignored");
   AST_SKIP_SEL: assert property (@(posedge sys_clk) disable iff (!reset_n)
      sw_q.force_dialog |-> mode_d != BSC_MODE_SINGLE) // RULE6
      else $error("boot select used under dialog");
   AST_SEL_EN: assert property (@(posedge sys_clk) disable iff (!reset_n)
      !setup_q[`BSC_SETUP_SELEN] |-> mode_d != BSC_MODE_SINGLE) // RULE7
      else $error("select used while not enabled");
   AST_SINGLE: assert property (@(posedge sys_clk) disable iff (!reset_n)
      state_q == BSC_ST_DECIDE && mode_d == BSC_MODE_SINGLE |=> entry_q == $past(sw_q.boot_sel)) // RULE8
      else $error("wrong boot entry");
   AST_FAIL: assert property (@(posedge sys_clk) disable iff (!reset_n)
      state_q == BSC_ST_RUN && mode_q == BSC_MODE_SINGLE && boot_failed
      |=> booterr_q ##1 mode_q == BSC_MODE_DIALOG) // RULE9
      else $error("failed boot did not fall back");
   AST_ZERO_SEL: assert property (@(posedge sys_clk) disable iff (!reset_n)
      !sw_q.force_dialog && sw_q.boot_sel == 3'h0 |-> mode_d == (sw_q.console_en ?
      BSC_MODE_MONITOR : BSC_MODE_SELFTST)) // RULE10
      else $error("zero select mode wrong");
   AST_ONES_SEL: assert property (@(posedge sys_clk) disable iff (!reset_n)
      !sw_q.force_dialog && sw_q.boot_sel == 3'h7 && !sw_q.console_en
      |-> mode_d == BSC_MODE_AUTO) // RULE13
      else $error("all-ones select without console not auto");
   AST_STORED: assert property (@(posedge sys_clk) disable iff (!reset_n)
      !sw_q.force_dialog && sw_q.boot_sel == `BSC_SEL_ALL && sw_q.console_en
      |-> mode_d == BSC_MODE_STORED) // RULE12
      else $error("all-ones select with console not stored mode");
   AST_CONSOLE_ON: assert property (@(posedge sys_clk) disable iff (!reset_n)
      sw_q.console_en |=> console_txd == $past(tx_in)) // RULE14
      else $error("enabled console does not pass transmit data");
   AST_MUTE: assert property (@(posedge sys_clk) disable iff (!reset_n)
      !sw_q.console_en |=> console_txd) // RULE15
      else $error("transmit not muted");
   AST_RXERR: assert property (@(posedge sys_clk) disable iff (!reset_n)
      rx_char_strobe && !sw_q.console_en |=> console_disabled_err) // RULE16
      else $error("missing console disabled error");
   AST_NO_WRITE: assert property (@(posedge sys_clk) disable iff (!reset_n)
      wr && paddr == `BSC_OFF_SWCFG |=> sw_q == $past({remote_cable_high_switches,
      remote_cable_low_switches})) // RULE18
      else $error("switch register took a write");

   COV_MONITOR: cover property (@(posedge sys_clk) mode_q == BSC_MODE_MONITOR);
   COV_SINGLE:  cover property (@(posedge sys_clk) mode_q == BSC_MODE_SINGLE);
   COV_FALL:    cover property (@(posedge sys_clk) booterr_q);
   COV_RXERR:   cover property (@(posedge sys_clk) console_disabled_err);

endmodule : bsc_switch_config

// ---- bsc_switch_panel.sv ----
// Purpose: Model of the panel switches and remote grounding contacts
// Assumes: Local switchpack all off, remote side grounds a line for on
// Notes:   Lines are pulled up; an open line reads high
module bsc_switch_panel (
   input  wire logic       sys_clk,
   input  wire logic [1:8] sw_on,
   output logic      [3:0] remote_cable_high_switches,
   output logic      [3:0] remote_cable_low_switches
);
   timeunit 1ns;
   timeprecision 1ps;
   // ----------------------------------------------------------------------
   // Wired-AND of local switches (left off) and remote ground contacts
   // ----------------------------------------------------------------------
   logic [7:0] local_off;
   assign local_off = 8'hff;
   // Grounded line wins over pull-up; changed just after the edge
   always @(posedge sys_clk) begin
      remote_cable_high_switches <= local_off[7:4] & ~{sw_on[1], sw_on[2], sw_on[3], sw_on[4]};
      remote_cable_low_switches  <= local_off[3:0] & ~{sw_on[5], sw_on[6], sw_on[7], sw_on[8]};
   end
endmodule : bsc_switch_panel
